// *** logic/fli_pkg.sv ***
// Functional notes
// - Estimate ops give results; their flags untrusted
// - Underflow, overflow flags are status bits 0,1
// - Flags drive group 12 channels six, seven
// - Flags stay set until set_flags_op or a status move writes zero
// - Pending request taken when enable returns
// - Whole status register readable and writable
// - Other arithmetic sets flags on under/overflow
// - Execute stage three stall freezes stages two and three
// - Late consumer reads register file, no forwarding
// - Two-cycle result forwarded to read stage two
package fli_pkg;
    // ****************************************
    // Status register layout
    // ****************************************
    localparam int          STAT_W        = 32;
    localparam int          LUF_BIT       = 0;
    localparam int          LVF_BIT       = 1;
    localparam logic [31:0] FLAG_MASK     = 32'h0000_0003;
    localparam logic [31:0] STAT_RESET    = 32'h0000_0000;
    // ****************************************
    // Interrupt group layout
    // ****************************************
    localparam int          GRP_W         = 16;
    localparam int          CH_UF         = 6;
    localparam int          CH_OF         = 7;
    localparam logic [15:0] GRP_FLAG_MASK = 16'h00C0;
    localparam logic [15:0] GRP_RESET     = 16'h0000;
    // ****************************************
    // Pipeline
    // ****************************************
    localparam int          REG_AW        = 3;
    localparam int          DATA_W        = 32;
    typedef enum logic [2:0]
    {
        OP_NONE     = 3'b000,
        OP_MUL      = 3'b001,
        OP_ADD      = 3'b010,
        OP_SUB      = 3'b011,
        OP_MAC      = 3'b100,
        OP_RECIP    = 3'b101,
        OP_INVSQRT  = 3'b110,
        OP_OTHER    = 3'b111
    } fli_op_t;
endpackage

// *** logic/fli_rf_if.sv ***
`timescale 1ns/1ns
// Register file read and write port bundle
interface fli_rf_if;
    import fli_pkg::*;
    logic                 we;
    logic [REG_AW-1:0]    waddr;
    logic [DATA_W-1:0]    wdata;
    logic [REG_AW-1:0]    raddr;
    logic [DATA_W-1:0]    rdata;
    modport owner (input we, input waddr, input wdata, input raddr, output rdata);
    modport user  (output we, output waddr, output wdata, output raddr, input rdata);
endinterface

// *** logic/fli_regfile.sv ***
`timescale 1ns/1ns
// ****************************************
// FPU register file, registered read
// ****************************************
module fli_regfile
    import fli_pkg::*;
(
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst_n,
    // Ports
    fli_rf_if.owner   rf
);
    logic [DATA_W-1:0] mem [2**REG_AW];
    logic [DATA_W-1:0] next_rdata;

    // Write-through so a same-cycle write is seen by the read
    always_comb
    begin
        next_rdata = mem[rf.raddr];
        if (rf.we && rf.waddr == rf.raddr)
            next_rdata = rf.wdata;
    end

    // Storage has no reset; read data register does
    always_ff @(posedge clock)
    begin
        if (rf.we)
            mem[rf.waddr] <= rf.wdata;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            rf.rdata <= '0;
        else
            rf.rdata <= next_rdata;
    end
endmodule

// *** logic/fli_fpu_flags.sv ***
`timescale 1ns/1ns
// ****************************************
// FPU latched flags, group 12 routing and
// two-cycle result forwarding
// ****************************************
module fli_fpu_flags
    import fli_pkg::*;
(
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst_n,
    // Issue into execute stage one
    input  wire logic              issue_valid,
    input  wire fli_op_t           issue_op,
    input  wire logic [REG_AW-1:0] issue_dest,
    input  wire logic [DATA_W-1:0] issue_result,
    input  wire logic              issue_underflow,
    input  wire logic              issue_overflow,
    // Stall request in execute stage three
    input  wire logic              e3_stall,
    // Consumer operand at read stage two
    input  wire logic              r2_valid,
    input  wire logic [REG_AW-1:0] r2_src,
    // Set-flags instruction
    input  wire logic              set_flags_op_valid,
    input  wire logic              set_flags_op_luf_en,
    input  wire logic              set_flags_op_lvf_en,
    input  wire logic              set_flags_op_luf_val,
    input  wire logic              set_flags_op_lvf_val,
    // Status register move
    input  wire logic              stat_wr,
    input  wire logic [STAT_W-1:0] stat_wdata,
    output logic      [STAT_W-1:0] stat_rdata,
    // Interrupt expansion controller group 12
    input  wire logic              grp_ier_wr,
    input  wire logic [GRP_W-1:0]  grp_ier_wdata,
    input  wire logic              grp_ack,
    input  wire logic [GRP_W-1:0]  grp_ack_mask,
    output logic      [GRP_W-1:0]  grp_enable,
    output logic      [GRP_W-1:0]  grp_pending,
    output logic                   grp_irq,
    // Pipeline observation
    output logic                   pipe_hold,
    output logic      [DATA_W-1:0] r2_operand,
    output logic                   r2_operand_valid
);
    // ****************************************
    // Pipeline stages
    // ****************************************
    logic              e2_v, e3_v, next_e2_v, next_e3_v;
    fli_op_t           e2_op, e3_op, next_e2_op, next_e3_op;
    logic [REG_AW-1:0] e2_d, e3_d, next_e2_d, next_e3_d;
    logic [DATA_W-1:0] e2_r, e3_r, next_e2_r, next_e3_r;
    logic              e2_uf, e2_of, e3_uf, e3_of;
    logic              next_e2_uf, next_e2_of, next_e3_uf, next_e3_of;
    logic              fwd_hit, next_hold, rd_fwd, next_rd_fwd, rd_v, next_rd_v;
    logic [DATA_W-1:0] fwd_data, next_fwd_data, next_operand;
    logic [STAT_W-1:0] next_stat;
    logic [GRP_W-1:0]  next_en, next_pend, line_rise;
    logic [1:0]        line_prev, next_line_prev;
    logic              next_irq;
    logic [STAT_W-1:0] stat_reg;
    fli_rf_if          rf ();

    function automatic logic two_cycle(input fli_op_t op);
        two_cycle = (op == OP_MUL) || (op == OP_ADD) || (op == OP_SUB) || (op == OP_MAC);
    endfunction

    // Stall with stage three valid freezes stages two and three for the cycle; read stage runs on
    always_comb
    begin
        next_hold = e3_stall && e3_v;
        next_e2_v  = e2_v;
        next_e2_op = e2_op;
        next_e2_d  = e2_d;
        next_e2_r  = e2_r;
        next_e2_uf = e2_uf;
        next_e2_of = e2_of;
        next_e3_v  = e3_v;
        next_e3_op = e3_op;
        next_e3_d  = e3_d;
        next_e3_r  = e3_r;
        next_e3_uf = e3_uf;
        next_e3_of = e3_of;
        if (!next_hold)
        begin
            next_e2_v  = issue_valid;
            next_e2_op = issue_op;
            next_e2_d  = issue_dest;
            next_e2_r  = issue_result;
            next_e2_uf = issue_underflow;
            next_e2_of = issue_overflow;
            next_e3_v  = e2_v;
            next_e3_op = e2_op;
            next_e3_d  = e2_d;
            next_e3_r  = e2_r;
            next_e3_uf = e2_uf;
            next_e3_of = e2_of;
        end
    end

    // Register file written when producer leaves stage three
    assign rf.we    = e3_v && !next_hold;
    assign rf.waddr = e3_d;
    assign rf.wdata = e3_r;
    assign rf.raddr = r2_src;

    // Forward from stage three even while stalled; the old silicon lost this case
    always_comb
    begin
        fwd_hit       = r2_valid && e3_v && two_cycle(e3_op) && (e3_d == r2_src);
        next_rd_fwd   = fwd_hit;
        next_fwd_data = e3_r;
        next_rd_v     = r2_valid;
        // Producer gone: registered file read, already write-through
        next_operand  = rd_fwd ? fwd_data : rf.rdata;
    end

    // ****************************************
    // Latched flags and status register
    // ****************************************
    always_comb
    begin
        next_stat = stat_reg;
        if (stat_wr)
            next_stat = stat_wdata;
        if (set_flags_op_valid && set_flags_op_luf_en)
            next_stat[LUF_BIT] = set_flags_op_luf_val;
        if (set_flags_op_valid && set_flags_op_lvf_en)
            next_stat[LVF_BIT] = set_flags_op_lvf_val;
        // Estimate ops excluded: their flag outputs are not trusted
        if (e3_v && !next_hold && e3_op != OP_RECIP && e3_op != OP_INVSQRT)
        begin
            if (e3_uf)
                next_stat[LUF_BIT] = 1'b1;
            if (e3_of)
                next_stat[LVF_BIT] = 1'b1;
        end
    end

    // Group 12: rising flag lines latch pending; ack clears, set wins
    always_comb
    begin
        next_line_prev = next_stat[1:0] & 2'(FLAG_MASK);
        line_rise      = '0;
        line_rise[CH_UF] = next_line_prev[LUF_BIT] && !line_prev[LUF_BIT];
        line_rise[CH_OF] = next_line_prev[LVF_BIT] && !line_prev[LVF_BIT];
        next_en   = grp_ier_wr ? grp_ier_wdata : grp_enable;
        // Only the acknowledge path clears, so other channels are never lost
        next_pend = (grp_ack ? (grp_pending & ~grp_ack_mask) : grp_pending) | line_rise;
        // Held pending is taken as soon as its enable returns
        next_irq  = |(next_pend & next_en & GRP_FLAG_MASK);
    end

    // Registers only; every next value is worked out above
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            e2_v             <= 1'b0;
            e2_op            <= OP_NONE;
            e2_d             <= '0;
            e2_r             <= '0;
            e2_uf            <= 1'b0;
            e2_of            <= 1'b0;
            e3_v             <= 1'b0;
            e3_op            <= OP_NONE;
            e3_d             <= '0;
            e3_r             <= '0;
            e3_uf            <= 1'b0;
            e3_of            <= 1'b0;
            rd_fwd           <= 1'b0;
            fwd_data         <= '0;
            rd_v             <= 1'b0;
            pipe_hold        <= 1'b0;
            r2_operand       <= '0;
            r2_operand_valid <= 1'b0;
            stat_reg         <= STAT_RESET;
            stat_rdata       <= STAT_RESET;
            line_prev        <= 2'b00;
            grp_enable       <= GRP_RESET;
            grp_pending      <= GRP_RESET;
            grp_irq          <= 1'b0;
        end
        else
        begin
            e2_v             <= next_e2_v;
            e2_op            <= next_e2_op;
            e2_d             <= next_e2_d;
            e2_r             <= next_e2_r;
            e2_uf            <= next_e2_uf;
            e2_of            <= next_e2_of;
            e3_v             <= next_e3_v;
            e3_op            <= next_e3_op;
            e3_d             <= next_e3_d;
            e3_r             <= next_e3_r;
            e3_uf            <= next_e3_uf;
            e3_of            <= next_e3_of;
            rd_fwd           <= next_rd_fwd;
            fwd_data         <= next_fwd_data;
            rd_v             <= next_rd_v;
            pipe_hold        <= next_hold;
            r2_operand       <= next_operand;
            r2_operand_valid <= rd_v;
            stat_reg         <= next_stat;
            stat_rdata       <= next_stat;
            line_prev        <= next_line_prev;
            grp_enable       <= next_en;
            grp_pending      <= next_pend;
            grp_irq          <= next_irq;
        end
    end

    fli_regfile u_rf
    (
        .clock (clock),
        .rst_n (rst_n),
        .rf    (rf.owner)
    );
endmodule

// *** bench/fli_flags_props.sv ***
`timescale 1ns/1ns
// ***
// Flag and pipe checks
// ***
module fli_flags_props
    import fli_pkg::*;
(
    // Watched top ports
    input wire logic              clock,
    input wire logic              rst_n,
    input wire logic              stat_wr,
    input wire logic              set_flags_op_valid,
    input wire logic [STAT_W-1:0] stat_wdata,
    input wire logic [STAT_W-1:0] stat_rdata,
    input wire logic              grp_ack,
    input wire logic [GRP_W-1:0]  grp_ack_mask,
    input wire logic [GRP_W-1:0]  grp_enable,
    input wire logic [GRP_W-1:0]  grp_pending,
    input wire logic              grp_irq,
    input wire logic              e3_stall,
    input wire logic              pipe_hold,
    input wire logic              r2_valid,
    input wire logic              r2_operand_valid
);
    // One domain, so clock and reset are given once
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    move_keeps_a: assert property (stat_wr && !set_flags_op_valid |=>
        stat_rdata[31:2] == $past(stat_wdata[31:2])) else $error("move lost");
    flags_sticky_a: assert property ($fell(stat_rdata[0]) || $fell(stat_rdata[1]) |->
        $past(stat_wr) || $past(set_flags_op_valid)) else $error("flag dropped");
    uf_pending_a: assert property ($rose(stat_rdata[0]) |-> ##[0:1] grp_pending[6])
        else $error("uf line");
    of_pending_a: assert property ($rose(stat_rdata[1]) |-> ##[0:1] grp_pending[7])
        else $error("of line");
    irq_merge_a: assert property (grp_irq == |(grp_pending & grp_enable & GRP_FLAG_MASK))
        else $error("irq");
    pending_held_a: assert property ($fell(grp_pending[6]) |-> $past(grp_ack) && $past(grp_ack_mask[6]))
        else $error("pending lost");
    stall_hold_a: assert property (pipe_hold |-> $past(e3_stall)) else $error("hold");
    operand_time_a: assert property (r2_valid |-> ##[2:4] r2_operand_valid) else $error("operand late");
endmodule
bind fli_fpu_flags fli_flags_props u_props
(
    .clock            (clock),
    .rst_n            (rst_n),
    .stat_wr          (stat_wr),
    .set_flags_op_valid     (set_flags_op_valid),
    .stat_wdata       (stat_wdata),
    .stat_rdata       (stat_rdata),
    .grp_ack          (grp_ack),
    .grp_ack_mask     (grp_ack_mask),
    .grp_enable       (grp_enable),
    .grp_pending      (grp_pending),
    .grp_irq          (grp_irq),
    .e3_stall         (e3_stall),
    .pipe_hold        (pipe_hold),
    .r2_valid         (r2_valid),
    .r2_operand_valid (r2_operand_valid)
);

// *** bench/fli_irq_partner.sv ***
`timescale 1ns/1ns
// Group 12 controller side, answering after ack_delay cycles
module fli_irq_partner
    import fli_pkg::*;
(
    // Clock, reset, reply speed
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic [3:0]       ack_delay,
    // Group side
    input  wire logic             grp_irq,
    input  wire logic [GRP_W-1:0] grp_pending,
    input  wire logic [GRP_W-1:0] grp_enable,
    output logic                  grp_ack,
    output logic      [GRP_W-1:0] grp_ack_mask
);
    logic [3:0] wait_cnt;
    // Pending bits go only by acknowledge, never a direct clear
    assign grp_ack_mask = grp_pending & grp_enable & GRP_FLAG_MASK;
    // Reply delay counter; a slow handler lets requests pile up
    always_ff @(posedge clock or negedge rst_n)
        if (!rst_n)
            {grp_ack, wait_cnt} <= '0;
        else
        begin
            grp_ack  <= grp_irq && !grp_ack && wait_cnt == ack_delay;
            wait_cnt <= (grp_irq && !grp_ack && wait_cnt != ack_delay) ? wait_cnt + 4'h1 : 4'h0;
        end
endmodule

// *** bench/fli_fpu_flags_tb.sv ***
`timescale 1ns/1ns
// ***
// Bench for the latched flag unit
// ***
module fli_fpu_flags_tb
    import fli_pkg::*;
;
    logic clock, rst_n, issue_valid, issue_underflow, issue_overflow, e3_stall, r2_valid;
    logic set_flags_op_valid, set_flags_op_luf_en, set_flags_op_lvf_en, set_flags_op_luf_val, set_flags_op_lvf_val;
    logic stat_wr, grp_ier_wr, grp_ack, grp_irq, pipe_hold, r2_operand_valid;
    fli_op_t           issue_op;
    logic [REG_AW-1:0] issue_dest, r2_src;
    logic [DATA_W-1:0] issue_result, r2_operand;
    logic [STAT_W-1:0] stat_wdata, stat_rdata;
    logic [GRP_W-1:0]  grp_ier_wdata, grp_ack_mask, grp_enable, grp_pending;
    logic [3:0]        ack_delay;
    int                errors, cmp_count, cycles;
    fli_fpu_flags u_dut
    (
        .clock            (clock),
        .rst_n            (rst_n),
        .issue_valid      (issue_valid),
        .issue_op         (issue_op),
        .issue_dest       (issue_dest),
        .issue_result     (issue_result),
        .issue_underflow  (issue_underflow),
        .issue_overflow   (issue_overflow),
        .e3_stall         (e3_stall),
        .r2_valid         (r2_valid),
        .r2_src           (r2_src),
        .set_flags_op_valid     (set_flags_op_valid),
        .set_flags_op_luf_en    (set_flags_op_luf_en),
        .set_flags_op_lvf_en    (set_flags_op_lvf_en),
        .set_flags_op_luf_val   (set_flags_op_luf_val),
        .set_flags_op_lvf_val   (set_flags_op_lvf_val),
        .stat_wr          (stat_wr),
        .stat_wdata       (stat_wdata),
        .stat_rdata       (stat_rdata),
        .grp_ier_wr       (grp_ier_wr),
        .grp_ier_wdata    (grp_ier_wdata),
        .grp_ack          (grp_ack),
        .grp_ack_mask     (grp_ack_mask),
        .grp_enable       (grp_enable),
        .grp_pending      (grp_pending),
        .grp_irq          (grp_irq),
        .pipe_hold        (pipe_hold),
        .r2_operand       (r2_operand),
        .r2_operand_valid (r2_operand_valid)
    );
    fli_irq_partner u_part
    (
        .clock            (clock),
        .rst_n            (rst_n),
        .ack_delay        (ack_delay),
        .grp_irq          (grp_irq),
        .grp_pending      (grp_pending),
        .grp_enable       (grp_enable),
        .grp_ack          (grp_ack),
        .grp_ack_mask     (grp_ack_mask)
    );
    // 100 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Hang guard; the run needs fewer than a hundred cycles
    always @(posedge clock)
        if (++cycles == 3000)
        begin
            errors++;
            report_and_stop();
        end
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %0t %h %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("errors=%0d cmp=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic put_op(input fli_op_t op, input logic [2:0] d, input logic [31:0] res, input logic [1:0] vu);
        issue_op = op;
        {issue_valid, issue_dest, issue_result, issue_overflow, issue_underflow} = {1'b1, d, res, vu};
        tick(1);
        issue_valid = 1'b0;
    endtask
    // Reads src at stage two, optionally stalling stage three that cycle
    task automatic get_opnd(input logic [2:0] s, input logic st, input logic [31:0] exp);
        {r2_valid, r2_src, e3_stall} = {1'b1, s, st};
        tick(1);
        {r2_valid, e3_stall} = 2'b00;
        chk(32'(pipe_hold), 32'(st));
        for (int i = 0; i < 4 && r2_operand_valid !== 1'b1; i++)
            tick(1);
        chk(32'(r2_operand_valid), 32'h0000_0001);
        chk(r2_operand, exp);
    endtask
    // Moves in and out, then a request parked while its enable is off
    task automatic t_status;
        {stat_wr, stat_wdata} = {1'b1, 32'hA5A5_5A5B};
        tick(1);
        chk(stat_rdata, 32'hA5A5_5A5B);
        stat_wdata = 32'h0000_0000;
        tick(1);
        stat_wr = 1'b0;
        chk(stat_rdata, 32'h0000_0000);
        chk(32'(grp_pending), 32'h0000_00C0);
        chk(32'(grp_irq), 32'h0000_0000);
        {grp_ier_wr, grp_ier_wdata} = {1'b1, GRP_FLAG_MASK};
        tick(1);
        grp_ier_wr = 1'b0;
        chk(32'(grp_enable), 32'(GRP_FLAG_MASK));
        chk(32'(grp_irq), 32'h0000_0001);
        for (int i = 0; i < 20 && grp_pending !== 16'h0000; i++)
            tick(1);
        chk(32'(grp_pending), 32'h0000_0000);
    endtask
    // Every op kind but OP_NONE and OP_OTHER; estimate ops must leave the flags alone
    task automatic t_flags;
        fli_op_t    ops [6] = '{OP_RECIP, OP_INVSQRT, OP_MUL, OP_ADD, OP_SUB, OP_MAC};
        logic [1:0] vu [6] = '{2'b01, 2'b10, 2'b01, 2'b00, 2'b10, 2'b01};
        logic [1:0] want [6] = '{2'b00, 2'b00, 2'b01, 2'b01, 2'b11, 2'b11};
        foreach (ops[k])
        begin
            put_op(ops[k], 3'd1, 32'h3F80_0000, vu[k]);
            tick(4);
            chk(stat_rdata & FLAG_MASK, {30'h0, want[k]});
        end
        {set_flags_op_valid, set_flags_op_luf_en, set_flags_op_lvf_en, set_flags_op_luf_val, set_flags_op_lvf_val} = 5'b1_1000;
        tick(1);
        set_flags_op_valid = 1'b0;
        chk(stat_rdata, 32'h0000_0002);
    endtask
    // Stalled producer forwards; a late reader gets the register file
    task automatic t_fwd;
        put_op(OP_MUL, 3'd6, 32'h4049_0FDB, 2'b00);
        tick(1);
        get_opnd(3'd6, 1'b1, 32'h4049_0FDB);
        tick(3);
        get_opnd(3'd6, 1'b0, 32'h4049_0FDB);
        // Unstalled producer in stage three still forwards to the reader
        put_op(OP_ADD, 3'd5, 32'h4000_0000, 2'b00);
        tick(1);
        get_opnd(3'd5, 1'b0, 32'h4000_0000);
    endtask
    initial
    begin
        rst_n = 1'b0;
        issue_op = OP_NONE;
        {issue_valid, issue_dest, issue_result, issue_underflow, issue_overflow, e3_stall, r2_valid, r2_src} = '0;
        {set_flags_op_valid, set_flags_op_luf_en, set_flags_op_lvf_en, set_flags_op_luf_val, set_flags_op_lvf_val, stat_wr, stat_wdata} = '0;
        {grp_ier_wr, grp_ier_wdata} = '0;
        ack_delay = 4'h6;
        tick(3);
        rst_n = 1'b1;
        tick(1);
        t_status();
        ack_delay = 4'h0;
        t_flags();
        t_fwd();
        report_and_stop();
    end
endmodule
